// file: core/nvrd_decoder.sv
// host-side decoder for the non-volatile register-command parameter word
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module nvrd_decoder (
    input  wire logic        aclk,          // 50 MHz clock
    input  wire logic        aresetn,       // sync reset, active low
    input  wire logic [3:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // write strobes
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [3:0]  s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready,  // read data ready
    output logic             nv_rd_ok,      // read usable in selected mode
    output logic             nv_wr_ok,      // generic write usable
    output logic [2:0]       nv_addr_bytes, // register address bytes, 1..4
    output logic [4:0]       nv_dummy_cyc   // dummy cycles in selected mode
);

    ////////////////////////////////////////////////////////////////////////
    // decode

    // returns 1 in [4] for unsupported, else count in [3:0]
    function automatic logic [4:0] cyc_field(input logic [31:0] w, input int lsb);
        logic [3:0] c;
        c = w[lsb +: 4];
        cyc_field = (c == nvrd_pkg::CYC_NOSUP) ? 5'h10 : {1'b0, c};
    endfunction

    logic [31:0] param_q, param_d;
    logic [2:0]  mode_q, mode_d;
    logic [4:0]  sel;          // [4] unsupported, [3:0] count
    logic [4:0]  sel_cyc;
    logic [2:0]  abytes;

    always_comb begin
        logic [1:0] d1;
        d1 = param_q[nvrd_pkg::DUM1S_LSB +: 2];
        // own length, never the array's address length
        abytes = 3'(param_q[nvrd_pkg::ALEN_LSB +: 2]) + 3'h1;
        case (mode_q)
            nvrd_pkg::M_1S: begin
                case (d1)
                    nvrd_pkg::DUM_NONE:  sel = 5'h00;
                    nvrd_pkg::DUM_BYTE:  sel = 5'h00;
                    nvrd_pkg::DUM_FIELD: sel = cyc_field(param_q, nvrd_pkg::CYC1S_LSB);
                    default:             sel = 5'h10;
                endcase
            end
            nvrd_pkg::M_2S: sel = cyc_field(param_q, nvrd_pkg::CYC2S_LSB);
            nvrd_pkg::M_4S: sel = cyc_field(param_q, nvrd_pkg::CYC4S_LSB);
            nvrd_pkg::M_4D: sel = cyc_field(param_q, nvrd_pkg::CYC4D_LSB);
            nvrd_pkg::M_8S: sel = cyc_field(param_q, nvrd_pkg::CYC8S_LSB);
            nvrd_pkg::M_8D: sel = cyc_field(param_q, nvrd_pkg::CYC8D_LSB);
            default:        sel = 5'h10;
        endcase
        if (mode_q == nvrd_pkg::M_1S && d1 == nvrd_pkg::DUM_BYTE) begin
            sel_cyc = nvrd_pkg::DUM_BYTE_CYCLES;
        end else begin
            sel_cyc = {1'b0, sel[3:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    typedef enum logic [1:0] {W_IDLE, W_RESP} nvrd_wst_e;
    nvrd_wst_e   wst_q, wst_d;
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [3:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    logic        rd_ok_q, rd_ok_d, wr_ok_q, wr_ok_d;
    logic [2:0]  ab_q, ab_d;
    logic [4:0]  dc_q, dc_d;
    logic        awready_q, awready_d;
    logic        wready_q, wready_d;
    logic        bvalid_q, bvalid_d;
    logic        arready_q, arready_d;

    always_comb begin
        logic [31:0] nw;
        wst_d     = wst_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bresp_d   = bresp_q;
        param_d   = param_q;
        mode_d    = mode_q;
        nw        = param_q;
        if (wst_q == W_IDLE) begin
            if (s_axi_awvalid && awready_q) begin
                aw_have_d = 1'b1;
                awaddr_d  = s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                w_have_d = 1'b1;
                wdata_d  = s_axi_wdata;
                wstrb_d  = s_axi_wstrb;
            end
            if (aw_have_q && w_have_q) begin
                bresp_d = nvrd_pkg::RESP_OKAY;
                for (int b = 0; b < 4; b++) begin
                    if (wstrb_q[b]) begin
                        nw[8*b +: 8] = wdata_q[8*b +: 8];
                    end
                end
                case (awaddr_q)
                    nvrd_pkg::REG_PARAM: param_d = nw;
                    nvrd_pkg::REG_MODE:  begin
                        if (wstrb_q[0]) begin
                            mode_d = wdata_q[2:0];
                        end
                    end
                    default: bresp_d = nvrd_pkg::RESP_SLVERR;
                endcase
                wst_d     = W_RESP;
                aw_have_d = 1'b0;
                w_have_d  = 1'b0;
            end
        end else if (s_axi_bready) begin
            wst_d = W_IDLE;
        end
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q) begin
            if (s_axi_rready) begin
                rvalid_d = 1'b0;
            end
        end else if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = nvrd_pkg::RESP_OKAY;
            case (s_axi_araddr)
                nvrd_pkg::REG_PARAM: rdata_d = param_q;
                nvrd_pkg::REG_INFO:  rdata_d = {27'h0, param_q[nvrd_pkg::WR_SUP_BIT],
                                                param_q[nvrd_pkg::RD_SUP_BIT], abytes};
                nvrd_pkg::REG_MODE:  rdata_d = {29'h0, mode_q};
                nvrd_pkg::REG_DUMMY: rdata_d = {26'h0, sel[4], sel_cyc};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = nvrd_pkg::RESP_SLVERR;
                end
            endcase
        end
        // reserved bits 5:4 take no part in any decode
        rd_ok_d = param_q[nvrd_pkg::RD_SUP_BIT] && !sel[4];
        wr_ok_d = param_q[nvrd_pkg::WR_SUP_BIT];
        ab_d    = abytes;
        dc_d    = sel[4] ? 5'h00 : sel_cyc;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q     <= W_IDLE;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 4'h0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bresp_q   <= nvrd_pkg::RESP_OKAY;
            param_q   <= nvrd_pkg::PARAM_RST;
            mode_q    <= nvrd_pkg::MODE_RST;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= nvrd_pkg::RESP_OKAY;
            rd_ok_q   <= 1'b0;
            wr_ok_q   <= 1'b0;
            ab_q      <= 3'h1;
            dc_q      <= 5'h00;
        end else begin
            wst_q     <= wst_d;
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bresp_q   <= bresp_d;
            param_q   <= param_d;
            mode_q    <= mode_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            rd_ok_q   <= rd_ok_d;
            wr_ok_q   <= wr_ok_d;
            ab_q      <= ab_d;
            dc_q      <= dc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // handshake flags

    // ready flags leave flip-flops; they are worked out from the next state,
    // so each one stands exactly while its channel can take an item
    always_comb begin
        awready_d = (wst_d == W_IDLE) && !aw_have_d;
        wready_d  = (wst_d == W_IDLE) && !w_have_d;
        bvalid_d  = (wst_d == W_RESP);
        arready_d = !rvalid_d;
    end

    // readies stay low through reset and come up one edge after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            arready_q <= arready_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign nv_rd_ok      = rd_ok_q;
    assign nv_wr_ok      = wr_ok_q;
    assign nv_addr_bytes = ab_q;
    assign nv_dummy_cyc  = dc_q;

endmodule
`default_nettype wire

// file: common/nvrd_pkg.sv
// constants shared by the non-volatile register-command parameter decoder
package nvrd_pkg;
    // parameter word field layout
    localparam int RD_SUP_BIT    = 31;
    localparam int WR_SUP_BIT    = 30;
    localparam int ALEN_LSB      = 28;
    localparam int DUM1S_LSB     = 26;
    localparam int CYC2S_LSB     = 22;
    localparam int CYC4S_LSB     = 18;
    localparam int CYC4D_LSB     = 14;
    localparam int CYC8S_LSB     = 10;
    localparam int CYC8D_LSB     = 6;
    localparam int RSVD_LSB      = 4;
    localparam int CYC1S_LSB     = 0;
    // single-lane dummy codes
    localparam logic [1:0] DUM_NONE  = 2'h0;
    localparam logic [1:0] DUM_BYTE  = 2'h1;
    localparam logic [1:0] DUM_FIELD = 2'h2;
    localparam logic [1:0] DUM_NOSUP = 2'h3;
    localparam logic [3:0] CYC_NOSUP = 4'hF;
    localparam logic [4:0] DUM_BYTE_CYCLES = 5'h08;
    // axi4-lite register map (byte addresses)
    localparam logic [3:0] REG_PARAM  = 4'h0;
    localparam logic [3:0] REG_INFO   = 4'h4;
    localparam logic [3:0] REG_MODE   = 4'h8;
    localparam logic [3:0] REG_DUMMY  = 4'hC;
    localparam logic [31:0] PARAM_RST = 32'h0000_0000;
    localparam logic [2:0]  MODE_RST  = 3'h0;
    // bus mode selector codes
    localparam logic [2:0] M_1S = 3'h0;
    localparam logic [2:0] M_2S = 3'h1;
    localparam logic [2:0] M_4S = 3'h2;
    localparam logic [2:0] M_4D = 3'h3;
    localparam logic [2:0] M_8S = 3'h4;
    localparam logic [2:0] M_8D = 3'h5;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: dv/nvrd_dev_model.sv
// behavioural device side: publishes the read-only parameter word
`timescale 1ns/1ps
`default_nettype none
module nvrd_dev_model (
    input  wire logic [31:0] seed_word,  // raw field content chosen by the bench
    output logic      [31:0] param_word  // word as the device publishes it
);
    always_comb begin
        // support flags, address length and per-mode dummy codes pass as chosen
        param_word      = seed_word;
        // the device always leaves the reserved pair clear
        param_word[5:4] = 2'h0;
    end
endmodule
`default_nettype wire

// file: dv/nvrd_decoder_asserts.sv
// concurrent checks on the decoder's ports
`timescale 1ns/1ps
`default_nettype none
module nvrd_decoder_asserts (
    input wire logic        aclk, aresetn,                             // clock, sync reset
    input wire logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr,   // addresses, strobes
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, // write handshakes
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready,  // write handshakes
    input wire logic        s_axi_arvalid, s_axi_arready,              // read address
    input wire logic        s_axi_rvalid, s_axi_rready,                // read data
    input wire logic [31:0] s_axi_wdata, s_axi_rdata,                  // data
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp,                  // responses
    input wire logic        nv_rd_ok, nv_wr_ok,                        // decoded flags
    input wire logic [2:0]  nv_addr_bytes,                             // address bytes
    input wire logic [4:0]  nv_dummy_cyc                               // dummy cycles
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_par_wr;
        s_wr_taken ##0 (s_axi_awaddr == nvrd_pkg::REG_PARAM && s_axi_wstrb == 4'hF);
    endsequence
    // outputs settle one edge after the word lands, so two after capture; checked four edges on
    property p_decode;
        logic [31:0] d;
        (s_par_wr, d = s_axi_wdata) |-> ##4 (nv_wr_ok == d[30] && nv_addr_bytes == {1'b0, d[29:28]} + 3'h1);
    endproperty
    property p_rd_bit;
        logic [31:0] d;
        (s_par_wr, d = s_axi_wdata) |-> ##4 (!nv_rd_ok || d[31]);
    endproperty
    a_decode_fields: assert property (p_decode) else $error("decoded write flag or length wrong");
    a_rd_needs_bit: assert property (p_rd_bit) else $error("read usable without support bit");
    a_wr_resp_lat: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("write response late");
    a_rd_resp_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    a_b_no_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready busy");
    a_r_no_ready: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read ready while busy");
    a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("double resp");
    a_addr_range: assert property (nv_addr_bytes >= 3'h1 && nv_addr_bytes <= 3'h4) else $error("bad length");
    a_dummy_range: assert property (nv_dummy_cyc <= 5'h0E) else $error("dummy count above 14");
endmodule
bind nvrd_decoder nvrd_decoder_asserts u_nvrd_decoder_asserts (.*);
`default_nettype wire

// file: dv/test_nvrd_decoder.sv
// self-checking bench for the parameter word decoder
`timescale 1ns/1ps
`default_nettype none
module test_nvrd_decoder;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, seed = 32'h0, rng = 32'hC6C9CA45, r, w;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, rd_ok, wr_ok;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata, pw;
    wire  [2:0]  abytes;
    wire  [4:0]  dcyc;
    logic [1:0]  resp;
    logic [5:0]  e;
    int          fail_count = 0, comparisons = 0;
    always #10 aclk = ~aclk;
    nvrd_dev_model u_nvrd_dev_model (.seed_word(seed), .param_word(pw));
    nvrd_decoder u_nvrd_decoder (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .nv_rd_ok(rd_ok), .nv_wr_ok(wr_ok), .nv_addr_bytes(abytes), .nv_dummy_cyc(dcyc));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // {unsupported, cycles}; 4'hF marks unsupported since counts stop at 14
    function automatic logic [5:0] exp_dum(input logic [31:0] x, input logic [2:0] m);
        logic [3:0] f;
        case (m)
            3'h0: f = (x[27:26] == 2'h0) ? 4'h0 : (x[27:26] == 2'h1) ? 4'h8 : (x[27:26] == 2'h2) ? x[3:0] : 4'hF;
            3'h1: f = x[25:22];
            3'h2: f = x[21:18];
            3'h3: f = x[17:14];
            3'h4: f = x[13:10];
            3'h5: f = x[9:6];
            default: f = 4'hF;
        endcase
        return (f == 4'hF) ? 6'h20 : {2'h0, f};
    endfunction
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        r = rdata;
        rready <= 1'b0;
    endtask
    task results();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        results();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(nvrd_pkg::REG_INFO);
        check(r, 32'h1);
        for (int i = 0; i < 16; i++) begin
            w = xs();
            if (i < 4) w[27:26] = i[1:0];
            if (i == 2) w[3:0] = 4'hF;
            if (i == 5) begin
                w[27:26] = 2'h2;
                w[3:0] = 4'hE;
            end
            seed <= w;
            @(posedge aclk);
            wr(nvrd_pkg::REG_PARAM, pw);
            check({30'h0, resp}, {30'h0, nvrd_pkg::RESP_OKAY});
            rd(nvrd_pkg::REG_INFO);
            check(r, {27'h0, pw[30], pw[31], {1'b0, pw[29:28]} + 3'h1});
            check({29'h0, abytes}, {29'h0, {1'b0, pw[29:28]} + 3'h1});
            check({31'h0, wr_ok}, {31'h0, pw[30]});
            for (int m = 0; m < 8; m++) begin
                wr(nvrd_pkg::REG_MODE, {29'h0, m[2:0]});
                e = exp_dum(pw, m[2:0]);
                rd(nvrd_pkg::REG_DUMMY);
                check(r, {26'h0, e});
                check({31'h0, rd_ok}, {31'h0, pw[31] && !e[5]});
                check({27'h0, dcyc}, {27'h0, e[4:0]});
            end
        end
        wr(nvrd_pkg::REG_INFO, 32'hFFFF_FFFF);
        check({30'h0, resp}, {30'h0, nvrd_pkg::RESP_SLVERR});
        wr(nvrd_pkg::REG_DUMMY, 32'h0000_0000);
        check({30'h0, resp}, {30'h0, nvrd_pkg::RESP_SLVERR});
        results();
    end
endmodule
`default_nettype wire
